// ===== hdl/fifo_ctrl_pkg.sv
// package: constants for the uart channel fifo control block
package fifo_ctrl_pkg;
   // -----------------------------------------------------------
   // sizes
   // -----------------------------------------------------------
   localparam int FIFO_DEPTH = 16; // characters per fifo
   localparam int CHAR_W     = 8;  // character width
   localparam int ADDR_W     = 3;  // register address width
   localparam int DATA_W     = 8;  // register data width
   localparam int CNT_W      = 5;  // fill count width, holds 0..16
   localparam int EVT_W      = 4;  // sticky event bits

   typedef logic [ADDR_W-1:0] reg_addr_t;
   typedef logic [DATA_W-1:0] reg_data_t;
   typedef logic [CNT_W-1:0]  fill_t;
   typedef logic [CHAR_W-1:0] char_t;

   // -----------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------
   localparam reg_addr_t OFF_FIFO_CTRL = 3'h0;
   localparam reg_addr_t OFF_SRC_VIEW  = 3'h1;
   localparam reg_addr_t OFF_RX_FILL   = 3'h2;
   localparam reg_addr_t OFF_TX_FILL   = 3'h3;
   localparam reg_addr_t OFF_EVT_STAT  = 3'h4;
   localparam reg_addr_t OFF_EVT_MASK  = 3'h5;

   // -----------------------------------------------------------
   // fifo control field positions and reset
   // -----------------------------------------------------------
   localparam int FC_ENABLE   = 0;
   localparam int FC_RX_FLUSH = 1;
   localparam int FC_TX_FLUSH = 2;
   localparam int FC_DMA_MODE = 3;
   localparam int FC_TRIG_LO  = 6;
   localparam int FC_TRIG_HI  = 7;
   localparam logic [1:0] FC_TRIG_RESET = 2'h0;

   // receive trigger levels per field code
   localparam fill_t TRIG_LVL_0 = 5'h01;
   localparam fill_t TRIG_LVL_1 = 5'h04;
   localparam fill_t TRIG_LVL_2 = 5'h08;
   localparam fill_t TRIG_LVL_3 = 5'h0E;

   // -----------------------------------------------------------
   // event bits, source view codes
   // -----------------------------------------------------------
   localparam int EV_RX_LEVEL = 0; // rx fill reached trigger
   localparam int EV_RX_TOUT  = 1; // rx time-out seen
   localparam int EV_RX_OVR   = 2; // char arrived with rx full
   localparam int EV_TX_EMPTY = 3; // tx fifo drained
   localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
   localparam logic [2:0] SRC_RX_DATA = 3'h2; // data available
   localparam logic [2:0] SRC_RX_TOUT = 3'h6; // data time-out
   localparam logic [2:0] SRC_NONE    = 3'h0;

   // trigger code to fill level
   function automatic fill_t trig_level(input logic [1:0] code);
      unique case (code)
         2'h0: trig_level = TRIG_LVL_0;
         2'h1: trig_level = TRIG_LVL_1;
         2'h2: trig_level = TRIG_LVL_2;
         2'h3: trig_level = TRIG_LVL_3;
      endcase
   endfunction
endpackage

// ===== hdl/char_fifo.sv
// flip-flop character fifo with flush and run-time fill limit
`timescale 1ns/1ps
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int CW    = 5
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   input  wire logic             flush,
   input  wire logic [CW-1:0]    limit,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic      [CW-1:0]    count,
   output logic                  full,
   output logic                  empty,
   output logic      [WIDTH-1:0] head
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   // refuse shapes the pointers cannot serve
   if (DEPTH < 2 || CW < $clog2(DEPTH + 1)) begin : g_bad
      $error("char_fifo: DEPTH or CW out of range");
   end

   logic [WIDTH-1:0] mem_q [DEPTH]; // storage entries
   logic [PW-1:0]    wr_q;          // write pointer
   logic [PW-1:0]    rd_q;          // read pointer
   logic             do_push;       // accepted write
   logic             do_pop;        // accepted read

   // limit of one gives holding-register behaviour
   assign full    = (count >= limit);
   assign empty   = (count == '0);
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign head    = mem_q[rd_q];

   // -----------------------------------------------------------
   // storage, one flop row per entry
   // -----------------------------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            mem_q[i] <= '0;
         end else if (clk_en && do_push && !flush && wr_q == PW'(i)) begin
            mem_q[i] <= push_data;
         end
      end
   end

   // pointers and count; flush beats any push or pop
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         count <= '0;
      end else if (clk_en) begin
         if (flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            count <= '0;
         end else begin
            if (do_push) begin
               wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (do_pop) begin
               rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
            count <= count + CW'(do_push) - CW'(do_pop);
         end
      end
   end
endmodule

// ===== hdl/dma_ready.sv
// transmit and receive dma ready pins for both signalling modes
`timescale 1ns/1ps
module dma_ready
   import fifo_ctrl_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  rstn,
   input  wire logic  clk_en,
   input  wire logic  mode1,
   input  wire logic  tx_empty,
   input  wire logic  tx_full,
   input  wire logic  rx_empty,
   input  wire logic  rx_level_ok,
   input  wire logic  rx_timeout,
   output logic       tx_dma_request_n,
   output logic       rx_dma_request_n
);
   logic rx_armed_q; // block request latched in mode 1
   logic rx_hit;     // trigger or time-out this cycle

   assign rx_hit = mode1 && (rx_level_ok || rx_timeout);

   // -----------------------------------------------------------
   // block mode latch
   // -----------------------------------------------------------
   // set wins over the empty clear so a late hit is not lost
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_armed_q <= 1'b0;
      end else if (clk_en) begin
         if (rx_hit) begin
            rx_armed_q <= 1'b1;
         end else if (rx_empty || !mode1) begin
            rx_armed_q <= 1'b0;
         end
      end
   end

   // pins combine state so they react in the same cycle
   always_comb begin
      if (mode1) begin
         tx_dma_request_n = tx_full;
         rx_dma_request_n = !(rx_hit || (rx_armed_q && !rx_empty));
      end else begin
         tx_dma_request_n = !tx_empty;
         rx_dma_request_n = rx_empty;
      end
   end
endmodule

// ===== hdl/uart_fifo_control_dma_ready.sv
// one uart channel: fifo control register, fifos, dma ready pins
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module uart_fifo_control_dma_ready
   import fifo_ctrl_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic              clk_en,
   input  wire fifo_ctrl_pkg::reg_addr_t reg_addr,
   input  wire fifo_ctrl_pkg::reg_data_t reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output fifo_ctrl_pkg::reg_data_t      reg_rdata,
   input  wire logic              tx_push,
   input  wire fifo_ctrl_pkg::char_t     tx_char,
   output logic                   tx_space,
   output logic                   tx_char_valid,
   output fifo_ctrl_pkg::char_t          tx_char_out,
   input  wire logic              tx_char_take,
   input  wire logic              rx_push,
   input  wire fifo_ctrl_pkg::char_t     rx_char,
   input  wire logic              rx_timeout,
   output logic                   rx_char_valid,
   output fifo_ctrl_pkg::char_t          rx_char_out,
   input  wire logic              rx_pop,
   output logic                   tx_dma_request_n,
   output logic                   rx_dma_request_n,
   output logic                   irq
);
   import fifo_ctrl_pkg::*;

   // depth must fit the fill counter and the trigger table
   if (DEPTH < int'(TRIG_LVL_3) || DEPTH >= (1 << CNT_W)) begin : g_bad
      $error("uart_fifo_control_dma_ready: DEPTH out of range");
   end

   // -----------------------------------------------------------
   // control register state
   // -----------------------------------------------------------
   logic             fifo_on_q;  // both fifos enabled
   logic             dma_mode_q; // dma signalling mode
   logic [1:0]       trig_q;     // rx trigger field
   logic [EVT_W-1:0] evt_q;      // sticky events
   logic [EVT_W-1:0] mask_q;     // event mask
   reg_data_t        rdata_q;    // registered read data

   // -----------------------------------------------------------
   // derived strobes
   // -----------------------------------------------------------
   logic       ctrl_wr;     // write to fifo control
   logic       en_change;   // enable bit toggles
   logic       tx_flush;    // empty tx fifo now
   logic       rx_flush;    // empty rx fifo now
   fill_t      tx_holding_register;         // current rx threshold
   fill_t      limit;       // fill limit for both fifos
   fill_t      tx_count;    // tx fill
   fill_t      rx_count;    // rx fill
   logic       tx_full;     // tx fifo full
   logic       tx_empty;    // tx fifo empty
   logic       rx_full;     // rx fifo full
   logic       rx_empty;    // rx fifo empty
   logic       rx_acc;      // rx char accepted
   logic       tx_pop;      // tx char leaves
   logic       rx_level_ok; // fill at or above trigger
   logic       rx_tout;     // time-out counted in fifo mode
   logic       mode1;       // block dma mode active
   logic [EVT_W-1:0] evt_set; // events of this cycle
   logic [EVT_W-1:0] evt_clr; // write-one-to-clear bits
   reg_data_t  ctrl_view;   // control readback
   reg_data_t  src_view;    // interrupt source view

   assign ctrl_wr   = reg_wr && (reg_addr == OFF_FIFO_CTRL);
   assign en_change = ctrl_wr && (reg_wdata[FC_ENABLE] != fifo_on_q);

   // flush bits act only with bit 0 set; they are pulses, never stored
   // so they read back as zero right after the flush
   // an enable change also empties both fifos so no stale data survives
   assign tx_flush = (ctrl_wr && reg_wdata[FC_ENABLE] && reg_wdata[FC_TX_FLUSH]) || en_change;
   assign rx_flush = (ctrl_wr && reg_wdata[FC_ENABLE] && reg_wdata[FC_RX_FLUSH]) || en_change;

   assign tx_holding_register   = trig_level(trig_q);
   // disabled fifos behave as single holding registers
   assign limit = fifo_on_q ? fill_t'(DEPTH) : fill_t'(1);
   assign mode1 = fifo_on_q && dma_mode_q;

   // -----------------------------------------------------------
   // fifo control register
   // -----------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fifo_on_q  <= 1'b0;
         dma_mode_q <= 1'b0;
         trig_q     <= FC_TRIG_RESET;
      end else if (clk_en && ctrl_wr) begin
         fifo_on_q <= reg_wdata[FC_ENABLE];
         if (reg_wdata[FC_ENABLE]) begin
            dma_mode_q <= reg_wdata[FC_DMA_MODE];
            trig_q     <= reg_wdata[FC_TRIG_HI:FC_TRIG_LO];
         end
      end
   end

   // -----------------------------------------------------------
   // the two fifos; state is per instance, nothing shared
   // -----------------------------------------------------------
   assign tx_pop = tx_char_take && !tx_empty;
   // trigger does not gate pushes, only a full fifo does
   assign rx_acc = rx_push && !rx_full;

   char_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (DEPTH),
      .CW    (CNT_W)
   ) u_tx_fifo (
      .clock     (clock),
      .rstn      (rstn),
      .clk_en    (clk_en),
      .flush     (tx_flush),
      .limit     (limit),
      .push      (tx_push),
      .push_data (tx_char),
      .pop       (tx_char_take),
      .count     (tx_count),
      .full      (tx_full),
      .empty     (tx_empty),
      .head      (tx_char_out)
   );

   char_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (DEPTH),
      .CW    (CNT_W)
   ) u_rx_fifo (
      .clock     (clock),
      .rstn      (rstn),
      .clk_en    (clk_en),
      .flush     (rx_flush),
      .limit     (limit),
      .push      (rx_push),
      .push_data (rx_char),
      .pop       (rx_pop),
      .count     (rx_count),
      .full      (rx_full),
      .empty     (rx_empty),
      .head      (rx_char_out)
   );

   assign tx_space      = !tx_full;
   assign tx_char_valid = !tx_empty;
   assign rx_char_valid = !rx_empty;

   // level stays true while fill is at or above trigger
   assign rx_level_ok = fifo_on_q && (rx_count >= tx_holding_register);
   assign rx_tout     = fifo_on_q && rx_timeout;

   // -----------------------------------------------------------
   // dma ready pins
   // -----------------------------------------------------------
   dma_ready u_ready (
      .clock            (clock),
      .rstn             (rstn),
      .clk_en           (clk_en),
      .mode1            (mode1),
      .tx_empty         (tx_empty),
      .tx_full          (tx_full),
      .rx_empty         (rx_empty),
      .rx_level_ok      (rx_level_ok),
      .rx_timeout       (rx_tout),
      .tx_dma_request_n (tx_dma_request_n),
      .rx_dma_request_n (rx_dma_request_n)
   );

   // -----------------------------------------------------------
   // sticky events and interrupt
   // -----------------------------------------------------------
   always_comb begin
      evt_set = '0;
      // fill steps onto the trigger exactly, flush suppresses it
      evt_set[EV_RX_LEVEL] = fifo_on_q && rx_acc && !rx_pop && !rx_flush
                             && (rx_count + 1'b1 == tx_holding_register);
      evt_set[EV_RX_TOUT]  = rx_tout;
      evt_set[EV_RX_OVR]   = rx_push && rx_full && !rx_flush;
      evt_set[EV_TX_EMPTY] = tx_pop && !tx_push && (tx_count == fill_t'(1));
   end

   assign evt_clr = (reg_wr && reg_addr == OFF_EVT_STAT) ? reg_wdata[EVT_W-1:0] : '0;

   // set beats a simultaneous write-one clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         evt_q <= EVT_RESET;
      end else if (clk_en) begin
         evt_q <= (evt_q & ~evt_clr) | evt_set;
      end
   end

   // mask register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mask_q <= EVT_RESET;
      end else if (clk_en && reg_wr && reg_addr == OFF_EVT_MASK) begin
         mask_q <= reg_wdata[EVT_W-1:0];
      end
   end

   assign irq = |(evt_q & mask_q);

   // -----------------------------------------------------------
   // read views
   // -----------------------------------------------------------
   always_comb begin
      ctrl_view = '0; // flush bits and bits 5:4 read as zero
      ctrl_view[FC_ENABLE]             = fifo_on_q;
      ctrl_view[FC_DMA_MODE]           = dma_mode_q;
      ctrl_view[FC_TRIG_HI:FC_TRIG_LO] = trig_q;
   end

   // data-available drops as soon as fill falls below trigger
   always_comb begin
      src_view = '0;
      src_view[DATA_W-1] = fifo_on_q;
      src_view[DATA_W-2] = fifo_on_q;
      if (rx_level_ok) begin
         src_view[3:1] = SRC_RX_DATA;
      end else if (fifo_on_q && evt_q[EV_RX_TOUT] && !rx_empty) begin
         src_view[3:1] = SRC_RX_TOUT;
      end else begin
         src_view[3:1] = SRC_NONE;
      end
      src_view[0] = (src_view[3:1] == SRC_NONE); // high means nothing pending
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= '0;
      end else if (clk_en) begin
         if (reg_rd) begin
            unique case (reg_addr)
               OFF_FIFO_CTRL: rdata_q <= ctrl_view;
               OFF_SRC_VIEW:  rdata_q <= src_view;
               OFF_RX_FILL:   rdata_q <= DATA_W'(rx_count);
               OFF_TX_FILL:   rdata_q <= DATA_W'(tx_count);
               OFF_EVT_STAT:  rdata_q <= DATA_W'(evt_q);
               OFF_EVT_MASK:  rdata_q <= DATA_W'(mask_q);
               default:       rdata_q <= '0; // unmapped reads zero
            endcase
         end else begin
            rdata_q <= '0;
         end
      end
   end

   assign reg_rdata = rdata_q;

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   property p_rx_level_evt;
      @(posedge clock) disable iff (!rstn)
      (clk_en && fifo_on_q && rx_acc && !rx_pop && !rx_flush && rx_count == tx_holding_register - 1'b1)
      |=> evt_q[EV_RX_LEVEL] && rx_count == tx_holding_register;
   endproperty
   a_rx_level_evt: assert property (p_rx_level_evt) else $error("rx level event missed");

   property p_trig_map;
      @(posedge clock) disable iff (!rstn)
      tx_holding_register == ((trig_q == 2'h0) ? 5'd1 : (trig_q == 2'h1) ? 5'd4 : (trig_q == 2'h2) ? 5'd8 : 5'd14);
   endproperty
   a_trig_map: assert property (p_trig_map) else $error("trigger level wrong");

   property p_rx_fills_on;
      @(posedge clock) disable iff (!rstn)
      (clk_en && fifo_on_q && rx_push && !rx_pop && !rx_flush && rx_count >= tx_holding_register
       && rx_count < fill_t'(DEPTH)) |=> rx_count == $past(rx_count) + 1'b1;
   endproperty
   a_rx_fills_on: assert property (p_rx_fills_on) else $error("rx stopped at trigger");

   property p_unused_zero;
      @(posedge clock) disable iff (!rstn)
      (clk_en && reg_rd && reg_addr == OFF_FIFO_CTRL) |=> reg_rdata[5:1] == {2'b00, dma_mode_q, 2'b00};
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused control bits set");

   property p_dma_sel;
      @(posedge clock) disable iff (!rstn)
      (clk_en && ctrl_wr && reg_wdata[FC_ENABLE]) |=> mode1 == $past(reg_wdata[FC_DMA_MODE]);
   endproperty
   a_dma_sel: assert property (p_dma_sel) else $error("dma mode not taken");

   property p_tx_mode0;
      @(posedge clock) disable iff (!rstn)
      !mode1 |-> tx_dma_request_n == (tx_count != '0);
   endproperty
   a_tx_mode0: assert property (p_tx_mode0) else $error("tx ready wrong in mode 0");

   property p_rx_mode0;
      @(posedge clock) disable iff (!rstn)
      !mode1 |-> rx_dma_request_n == (rx_count == '0);
   endproperty
   a_rx_mode0: assert property (p_rx_mode0) else $error("rx ready wrong in mode 0");

   property p_tx_mode1;
      @(posedge clock) disable iff (!rstn)
      mode1 |-> tx_dma_request_n == (tx_count == fill_t'(DEPTH));
   endproperty
   a_tx_mode1: assert property (p_tx_mode1) else $error("tx ready wrong in mode 1");

   property p_rx_mode1_hold;
      @(posedge clock) disable iff (!rstn)
      (clk_en && mode1 && !rx_dma_request_n && !ctrl_wr && !rx_pop) |=> !rx_dma_request_n;
   endproperty
   a_rx_mode1_hold: assert property (p_rx_mode1_hold) else $error("rx ready released early");

   property p_tx_flush;
      @(posedge clock) disable iff (!rstn)
      (clk_en && ctrl_wr && reg_wdata[FC_ENABLE] && reg_wdata[FC_TX_FLUSH]) |=> tx_count == '0;
   endproperty
   a_tx_flush: assert property (p_tx_flush) else $error("tx flush failed");

   property p_rx_flush;
      @(posedge clock) disable iff (!rstn)
      (clk_en && ctrl_wr && reg_wdata[FC_ENABLE] && reg_wdata[FC_RX_FLUSH]) |=> rx_count == '0;
   endproperty
   a_rx_flush: assert property (p_rx_flush) else $error("rx flush failed");

   property p_ignore_wr;
      @(posedge clock) disable iff (!rstn)
      (clk_en && ctrl_wr && !reg_wdata[FC_ENABLE]) |=> !fifo_on_q && $stable(trig_q) && $stable(dma_mode_q);
   endproperty
   a_ignore_wr: assert property (p_ignore_wr) else $error("write without enable took effect");

   property p_src_top;
      @(posedge clock) disable iff (!rstn)
      (clk_en && reg_rd && reg_addr == OFF_SRC_VIEW) |=> reg_rdata[7:6] == {2{$past(fifo_on_q)}};
   endproperty
   a_src_top: assert property (p_src_top) else $error("source view top bits wrong");
endmodule

// ===== sim/dma_host_model.sv
// dma controller model that drains the receive fifo on request
`timescale 1ns/1ps
module dma_host_model (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic drain,
   input  wire logic rx_dma_request_n,
   input  wire logic rx_char_valid,
   output logic      rx_pop
);
   // one pop a cycle while asked; the lagging pop on empty is refused by the fifo
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_pop <= 1'b0;
      end else begin
         rx_pop <= drain & ~rx_dma_request_n & rx_char_valid;
      end
   end
endmodule

// ===== sim/uart_fifo_control_dma_ready_test.sv
// self-checking bench for the fifo control and dma ready block
`timescale 1ns/1ps
module uart_fifo_control_dma_ready_test;
   import fifo_ctrl_pkg::*;
   logic      clock, rstn, reg_wr, reg_rd, tx_push, rx_push, rx_pop, drain;
   logic      tx_space, tx_char_valid, rx_char_valid, tx_dma_request_n, rx_dma_request_n, irq;
   logic      rx_tout, tx_take;  // time-out pulse and shifter take, driven by the bench
   char_t     tx_head, rx_head;  // fifo heads as the shifters see them
   reg_addr_t reg_addr;
   reg_data_t reg_wdata, reg_rdata;
   char_t     tx_char, rx_char;
   fill_t     lvl_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h0E}; // trigger per code
   int        fail_count = 0;
   int        n_compared = 0;
   int        cycles     = 0;

   uart_fifo_control_dma_ready dut (.clock(clock), .rstn(rstn), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_push(tx_push),
      .tx_char(tx_char), .tx_space(tx_space), .tx_char_valid(tx_char_valid), .tx_char_out(tx_head),
      .tx_char_take(tx_take), .rx_push(rx_push), .rx_char(rx_char), .rx_timeout(rx_tout),
      .rx_char_valid(rx_char_valid), .rx_char_out(rx_head), .rx_pop(rx_pop),
      .tx_dma_request_n(tx_dma_request_n), .rx_dma_request_n(rx_dma_request_n), .irq(irq));
   dma_host_model host (.clock(clock), .rstn(rstn), .drain(drain), .rx_dma_request_n(rx_dma_request_n),
      .rx_char_valid(rx_char_valid), .rx_pop(rx_pop));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one-cycle write strobe beside address and data
   task automatic wr(input reg_addr_t a, input reg_data_t d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1; // state written at this edge has settled on return
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input reg_addr_t a, input reg_data_t exp, input string what);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(what, reg_rdata, exp);
   endtask
   // one character into the rx or tx fifo, outputs settled on return
   task automatic push(input logic rx, input char_t c);
      @(posedge clock);
      rx_push <= rx;
      tx_push <= ~rx;
      rx_char <= c;
      tx_char <= c;
      @(posedge clock);
      rx_push <= 1'b0;
      tx_push <= 1'b0;
      #1;
   endtask
   task automatic pins(input logic t, input logic r);
      check("pins", {6'h0, tx_dma_request_n, rx_dma_request_n}, {6'h0, t, r});
   endtask

   // hang guard: far above the few hundred cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles > 5000) begin
         fail_count++;
         test_done;
      end
   end

   initial begin
      {reg_wr, reg_rd, tx_push, rx_push, drain, rx_tout, tx_take} = '0;
      {reg_addr, reg_wdata, tx_char, rx_char} = '0;
      rstn = 1'b0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      rdc(OFF_FIFO_CTRL, 8'h00, "ctrl");
      pins(1'b0, 1'b1);
      rdc(OFF_SRC_VIEW, 8'h01, "source");
      wr(OFF_FIFO_CTRL, 8'h3F);
      rdc(OFF_FIFO_CTRL, 8'h09, "ctrl");
      rdc(OFF_SRC_VIEW, 8'hC1, "source");
      wr(OFF_FIFO_CTRL, 8'hC8);
      rdc(OFF_FIFO_CTRL, 8'h08, "ctrl");
      wr(OFF_EVT_MASK, 8'h01);
      // every trigger code in mode 1, fill on past the trigger up to full
      for (int c = 0; c < 4; c++) begin
         wr(OFF_FIFO_CTRL, {c[1:0], 6'h0B});
         wr(OFF_EVT_STAT, 8'h0F);
         for (int n = 1; n <= FIFO_DEPTH; n++) begin
            push(1'b1, n[7:0]);
            check("rx_n", {7'h0, rx_dma_request_n}, {7'h0, n < lvl_tab[c]});
            if (n == lvl_tab[c]) check("irq", {7'h0, irq}, 8'h01);
         end
         rdc(OFF_RX_FILL, 8'h10, "rx fill");
      end
      wr(OFF_EVT_STAT, 8'h01);
      #1 check("irq", {7'h0, irq}, 8'h00);
      drain <= 1'b1;
      for (int k = 0; k < 40 && rx_char_valid; k++) begin
         check("rx_n", {7'h0, rx_dma_request_n}, 8'h00);
         check("rx head", rx_head, (k < 2) ? 8'h01 : k[7:0]);
         @(posedge clock);
         #1;
      end
      drain <= 1'b0;
      pins(1'b0, 1'b1);
      rdc(OFF_SRC_VIEW, 8'hC1, "source");
      for (int n = 1; n <= FIFO_DEPTH; n++) begin
         push(1'b0, n[7:0]);
         check("tx_n", {7'h0, tx_dma_request_n}, {7'h0, n == FIFO_DEPTH});
      end
      wr(OFF_FIFO_CTRL, 8'hCD);
      rdc(OFF_TX_FILL, 8'h00, "tx fill");
      pins(1'b0, 1'b1);
      // mode 1 time-out below the trigger: request holds until the fifo empties
      push(1'b1, 8'h33);
      pins(1'b0, 1'b1);
      @(posedge clock);
      rx_tout <= 1'b1;
      @(posedge clock);
      rx_tout <= 1'b0;
      #1 pins(1'b0, 1'b0);
      rdc(OFF_SRC_VIEW, 8'hCC, "source");
      pins(1'b0, 1'b0);
      wr(OFF_FIFO_CTRL, 8'hCB);
      pins(1'b0, 1'b1);
      wr(OFF_FIFO_CTRL, 8'h01);
      push(1'b0, 8'hA5);
      push(1'b1, 8'h5A);
      pins(1'b1, 1'b0);
      check("tx head", tx_head, 8'hA5);
      check("rx head", rx_head, 8'h5A);
      check("flags", {5'h0, tx_space, tx_char_valid, rx_char_valid}, 8'h07);
      // shifter takes the only tx char: tx request goes low again
      @(posedge clock);
      tx_take <= 1'b1;
      @(posedge clock);
      tx_take <= 1'b0;
      #1 pins(1'b0, 1'b0);
      wr(OFF_FIFO_CTRL, 8'h00);
      pins(1'b0, 1'b1);
      push(1'b1, 8'h11);
      push(1'b1, 8'h22);
      rdc(OFF_RX_FILL, 8'h01, "rx fill");
      wr(3'h7, 8'hFF);
      rdc(3'h7, 8'h00, "unmapped");
      test_done;
   end
endmodule
